// >>> fasu_pkg.sv
/*
  constants and types for the floating add and subtract unit:
  word layout, opcodes, special operand codes and exponent figures.
  assumes 60-bit one's complement floating words with a biased exponent.
*/
`default_nettype none

package fasu_pkg;

  // ******************************************************
  // widths
  // ******************************************************
  localparam int WORD_W    = 60;
  localparam int EXP_W     = 11;
  localparam int COEF_W    = 48;
  localparam int ACC_W     = 96;
  localparam int EXT_W     = 98;
  localparam int OPC_W     = 6;
  localparam int SEL_W     = 3;
  localparam int TOP_W     = 12;
  localparam int SIGN_POS  = 59;
  localparam int EXP_LO    = 48;
  localparam int OVF_POS   = 96;

  // ******************************************************
  // opcodes (octal 30 to 35)
  // ******************************************************
  localparam logic [OPC_W-1:0] OPC_SUM   = 6'h18;
  localparam logic [OPC_W-1:0] OPC_DIFF  = 6'h19;
  localparam logic [OPC_W-1:0] OPC_DSUM  = 6'h1a;
  localparam logic [OPC_W-1:0] OPC_DDIFF = 6'h1b;
  localparam logic [OPC_W-1:0] OPC_RSUM  = 6'h1c;
  localparam logic [OPC_W-1:0] OPC_RDIFF = 6'h1d;

  // ******************************************************
  // leading twelve bits of special operands
  // ******************************************************
  localparam logic [TOP_W-1:0] TOP_INF_POS = 12'h7ff;
  localparam logic [TOP_W-1:0] TOP_INF_NEG = 12'h800;
  localparam logic [TOP_W-1:0] TOP_IND_POS = 12'h3ff;
  localparam logic [TOP_W-1:0] TOP_IND_NEG = 12'hc00;

  // ******************************************************
  // exponent figures
  // ******************************************************
  localparam logic signed [EXP_W:0] EXP_BIAS       = 12'sh400;
  localparam logic signed [EXP_W:0] DBL_EXP_OFFSET = 12'sh030;
  localparam logic [EXP_W:0]        FILL_LIMIT     = 12'h080;
  localparam logic [EXT_W-1:0]      HALF_LSB       = 98'h0_0000_0000_0000_8000_0000_0000;

  typedef enum logic [1:0] {
    FASU_PREC_SINGLE,
    FASU_PREC_DOUBLE,
    FASU_PREC_ROUND
  } fasu_prec_type;

endpackage

`default_nettype wire

// >>> fasu_float_add_sub.sv
/*
  floating add and subtract functional unit: decodes six opcodes,
  reads two operand registers, writes one result one clock later.
  assumes the operand register file answers its read selects in the
  same cycle, on the same clock, and that issue holds no other opcodes.
*/
// What this block does
// RL1 - opcode 30 plain sum, 32 double low-half sum, 34 rounded sum
// RL2 - opcodes 31, 33, 35 are the matching differences, j minus k
// RL3 - operands come from registers j and k, result goes to register i
// RL4 - shift smaller-exponent coefficient right by exponent difference
// RL5 - single sum: 96-bit sum, upper half packed with larger exponent
// RL6 - double sum: lower half packed with larger exponent minus 48
// RL7 - coefficient overflow shifts result right one, exponent plus one
// RL8 - result is never normalized; leading zeros stay
// RL9 - exponent difference above 128 fills shifted operand with its sign
// RL10 - leading 3777 or 4000 is infinite and raises its exit condition
// RL11 - leading 1777 or 6000 is indefinite and raises its exit condition
// RL12 - rounded op: round bit to larger-exponent coefficient, tie goes to k
// RL13 - round bit is complement of sign, half an lsb below the coefficient
// RL14 - rounded sum: second round bit if both normalized or signs differ
// RL15 - second round bit goes in before the alignment shift
// RL16 - plain difference: 96-bit j minus k, upper half with larger exponent
// RL17 - like-sign difference keeps leading zeros
// RL18 - double difference: lower half with larger exponent minus 48
// RL19 - rounded difference: second round bit if both normalized or like signs
// RL20 - word is sign, 11-bit biased exponent, 48-bit coefficient
// RL21 - issue gives opcode and three register fields; one result plus flags
`timescale 1ns/1ps
`default_nettype none

module fasu_float_add_sub
  import fasu_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              rstn_i,
  input  wire logic              issue_valid_i,
  input  wire logic [OPC_W-1:0]  opcode_i,
  input  wire logic [SEL_W-1:0]  dest_operand_reg_i,
  input  wire logic [SEL_W-1:0]  first_source_reg_i,
  input  wire logic [SEL_W-1:0]  second_source_reg_i,
  output logic      [SEL_W-1:0]  first_source_sel_o,
  output logic      [SEL_W-1:0]  second_source_sel_o,
  input  wire logic [WORD_W-1:0] first_source_data_i,
  input  wire logic [WORD_W-1:0] second_source_data_i,
  output logic                   result_valid_o,
  output logic      [SEL_W-1:0]  result_dest_o,
  output logic      [WORD_W-1:0] result_data_o,
  output logic                   exit_infinite_o,
  output logic                   exit_indefinite_o
);

  // ******************************************************
  // functions
  // ******************************************************

  // positive form of a one's complement word
  function automatic logic [WORD_W-1:0] fold(input logic [WORD_W-1:0] w);
    return w[SIGN_POS] ? ~w : w; // [RL20]
  endfunction

  // unbiased exponent
  function automatic logic signed [EXP_W:0] true_exp(input logic [WORD_W-1:0] w);
    logic [WORD_W-1:0] f;
    f = fold(w);
    return $signed({1'b0, f[SIGN_POS-1:EXP_LO]}) - EXP_BIAS; // [RL20]
  endfunction

  function automatic logic normalized(input logic [WORD_W-1:0] w);
    logic [WORD_W-1:0] f;
    f = fold(w);
    return f[COEF_W-1];
  endfunction

  // coefficient placed in the upper accumulator half, round bit below its lsb
  function automatic logic signed [EXT_W-1:0] widen(input logic [WORD_W-1:0] w,
                                                     input logic              rnd);
    logic [WORD_W-1:0]        f;
    logic signed [EXT_W-1:0]  v;
    f = fold(w);
    v = $signed({2'b00, f[COEF_W-1:0], {COEF_W{1'b0}}});
    if (rnd)
    begin
      v = v + $signed(HALF_LSB); // [RL13]
    end
    return w[SIGN_POS] ? -v : v;
  endfunction

  // alignment shift, sign fill beyond the limit
  function automatic logic signed [EXT_W-1:0] align(input logic signed [EXT_W-1:0] v,
                                                     input logic [EXP_W:0]          amt);
    if (amt > FILL_LIMIT)
    begin
      return v[EXT_W-1] ? {EXT_W{1'b1}} : {EXT_W{1'b0}}; // [RL9]
    end
    return v >>> amt; // [RL4]
  endfunction

  function automatic logic is_inf(input logic [WORD_W-1:0] w);
    return (w[WORD_W-1 -: TOP_W] == TOP_INF_POS) || (w[WORD_W-1 -: TOP_W] == TOP_INF_NEG);
  endfunction

  function automatic logic is_ind(input logic [WORD_W-1:0] w);
    return (w[WORD_W-1 -: TOP_W] == TOP_IND_POS) || (w[WORD_W-1 -: TOP_W] == TOP_IND_NEG);
  endfunction

  // ******************************************************
  // decode
  // ******************************************************
  fasu_prec_type            prec;
  logic                     is_sub;
  logic                     op_legal;
  logic                     is_dbl;
  logic                     is_rnd;
  logic                     take;

  assign first_source_sel_o  = first_source_reg_i;  // [RL3]
  assign second_source_sel_o = second_source_reg_i; // [RL3]

  assign op_legal = (opcode_i == OPC_SUM) || (opcode_i == OPC_DSUM) || (opcode_i == OPC_RSUM)
                 || (opcode_i == OPC_DIFF) || (opcode_i == OPC_DDIFF) || (opcode_i == OPC_RDIFF); // [RL1] [RL2]
  assign is_sub   = (opcode_i == OPC_DIFF) || (opcode_i == OPC_DDIFF) || (opcode_i == OPC_RDIFF); // [RL2]
  assign prec     = ((opcode_i == OPC_DSUM) || (opcode_i == OPC_DDIFF)) ? FASU_PREC_DOUBLE
                  : ((opcode_i == OPC_RSUM) || (opcode_i == OPC_RDIFF)) ? FASU_PREC_ROUND
                  : FASU_PREC_SINGLE; // [RL1] [RL2]
  assign is_dbl   = (prec == FASU_PREC_DOUBLE);
  assign is_rnd   = (prec == FASU_PREC_ROUND);
  assign take     = issue_valid_i && op_legal; // [RL21]

  // ******************************************************
  // unpack and compare exponents
  // ******************************************************
  logic [WORD_W-1:0]        word_j;
  logic [WORD_W-1:0]        word_k;
  logic signed [EXP_W:0]    exp_j;
  logic signed [EXP_W:0]    exp_k;
  logic                     j_big;
  logic signed [EXP_W:0]    exp_big;
  logic [EXP_W:0]           exp_gap;

  assign word_j  = first_source_data_i;  // [RL3]
  assign word_k  = second_source_data_i; // [RL3]
  assign exp_j   = true_exp(word_j);
  assign exp_k   = true_exp(word_k);
  assign j_big   = exp_j > exp_k; // [RL12]
  assign exp_big = j_big ? exp_j : exp_k;
  assign exp_gap = j_big ? 12'(exp_j - exp_k) : 12'(exp_k - exp_j); // [RL4]

  // ******************************************************
  // round bits
  // ******************************************************
  logic                     both_norm;
  logic                     signs_differ;
  logic                     second_rnd;
  logic                     rnd_j;
  logic                     rnd_k;

  assign both_norm    = normalized(word_j) && normalized(word_k);
  assign signs_differ = word_j[SIGN_POS] ^ word_k[SIGN_POS];
  assign second_rnd   = both_norm || (is_sub ? !signs_differ : signs_differ); // [RL14] [RL19]
  assign rnd_j        = is_rnd && (j_big || second_rnd);  // [RL12] [RL14] [RL19]
  assign rnd_k        = is_rnd && (!j_big || second_rnd); // [RL12] [RL14] [RL19]

  // ******************************************************
  // align and add
  // ******************************************************
  logic signed [EXT_W-1:0]  ext_j;
  logic signed [EXT_W-1:0]  ext_k;
  logic signed [EXT_W-1:0]  al_j;
  logic signed [EXT_W-1:0]  al_k;
  logic signed [EXT_W-1:0]  raw_sum;
  logic                     res_neg;
  logic [EXT_W-1:0]         res_mag;
  logic                     coef_ovf;
  logic [EXT_W-1:0]         mag_adj;

  // round bits enter before the shift
  assign ext_j   = widen(word_j, rnd_j); // [RL15]
  assign ext_k   = widen(word_k, rnd_k); // [RL15]
  assign al_j    = j_big ? ext_j : align(ext_j, exp_gap); // [RL4]
  assign al_k    = j_big ? align(ext_k, exp_gap) : ext_k; // [RL4]
  assign raw_sum = is_sub ? al_j - al_k : al_j + al_k; // [RL5] [RL16]
  assign res_neg = raw_sum[EXT_W-1];
  assign res_mag = res_neg ? 98'(-raw_sum) : 98'(raw_sum);
  assign coef_ovf = res_mag[OVF_POS]; // [RL7]
  assign mag_adj = coef_ovf ? (res_mag >> 1) : res_mag; // [RL7]

  // ******************************************************
  // pack, no normalize step
  // ******************************************************
  logic signed [EXP_W:0]    exp_res;
  logic signed [EXP_W:0]    exp_out;
  logic [EXP_W-1:0]         exp_field;
  logic [COEF_W-1:0]        coef_out;
  logic [WORD_W-1:0]        float_result_plain;
  logic [WORD_W-1:0]        float_result_double_low;
  logic [WORD_W-1:0]        packed_pos;
  logic [WORD_W-1:0]        nxt_result_data;

  assign exp_res   = exp_big + $signed({{EXP_W{1'b0}}, coef_ovf}); // [RL7]
  assign exp_out   = is_dbl ? exp_res - DBL_EXP_OFFSET : exp_res; // [RL6] [RL18]
  assign exp_field = 11'(exp_out + EXP_BIAS); // [RL20]
  // leading zeros are left in place
  assign float_result_plain      = {1'b0, exp_field, mag_adj[ACC_W-1:COEF_W]}; // [RL5] [RL16] [RL8] [RL17]
  assign float_result_double_low = {1'b0, exp_field, mag_adj[COEF_W-1:0]};     // [RL6] [RL18]
  assign coef_out   = is_dbl ? float_result_double_low[COEF_W-1:0] : float_result_plain[COEF_W-1:0];
  assign packed_pos = {1'b0, exp_field, coef_out};
  assign nxt_result_data = res_neg ? ~packed_pos : packed_pos; // [RL20]

  // ******************************************************
  // exit conditions
  // ******************************************************
  logic                     nxt_inf;
  logic                     nxt_ind;

  assign nxt_inf = take && (is_inf(word_j) || is_inf(word_k)); // [RL10]
  assign nxt_ind = take && (is_ind(word_j) || is_ind(word_k)); // [RL11]

  // ******************************************************
  // result registers
  // ******************************************************
  logic                     result_valid_ff;
  logic [SEL_W-1:0]         result_dest_ff;
  logic [WORD_W-1:0]        result_data_ff;
  logic                     exit_inf_ff;
  logic                     exit_ind_ff;

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      result_valid_ff <= 1'b0;
      exit_inf_ff     <= 1'b0;
      exit_ind_ff     <= 1'b0;
    end
    else
    begin
      result_valid_ff <= take; // [RL21]
      exit_inf_ff     <= nxt_inf; // [RL10]
      exit_ind_ff     <= nxt_ind; // [RL11]
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      result_dest_ff <= '0;
      result_data_ff <= '0;
    end
    else if (take)
    begin
      result_dest_ff <= dest_operand_reg_i; // [RL3]
      result_data_ff <= nxt_result_data;    // [RL21]
    end
  end

  assign result_valid_o    = result_valid_ff;
  assign result_dest_o     = result_dest_ff;
  assign result_data_o     = result_data_ff;
  assign exit_infinite_o   = exit_inf_ff;
  assign exit_indefinite_o = exit_ind_ff;

  // ******************************************************
  // checks
  // ******************************************************
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);

  sequence s_issue_legal;
    issue_valid_i && op_legal;
  endsequence

  sequence s_result_out;
    result_valid_o ##1 !result_valid_o || $past(take, 1);
  endsequence

  property p_result_follows;
    s_issue_legal |=> s_result_out;
  endproperty
  a_result_follows: assert property (p_result_follows) else $error("result missing one cycle after issue"); // [RL21]

  property p_dest_kept;
    s_issue_legal |=> (result_dest_o == $past(dest_operand_reg_i));
  endproperty
  a_dest_kept: assert property (p_dest_kept) else $error("result register differs from i field"); // [RL3]

  property p_illegal_dropped;
    (issue_valid_i && !op_legal) |=> !result_valid_o && !exit_infinite_o && !exit_indefinite_o;
  endproperty
  a_illegal_dropped: assert property (p_illegal_dropped) else $error("unknown opcode produced output"); // [RL1]

  property p_self_diff_zero;
    (issue_valid_i && (opcode_i == OPC_DIFF) && (word_j == word_k)) |=> (result_data_o[COEF_W-1:0] == '0);
  endproperty
  a_self_diff_zero: assert property (p_self_diff_zero) else $error("x minus x left a coefficient"); // [RL2]

  property p_dbl_exponent;
    (s_issue_legal and (is_dbl && !res_neg && !coef_ovf))
      |=> (result_data_o[SIGN_POS-1:EXP_LO] == $past(11'(exp_big - DBL_EXP_OFFSET + EXP_BIAS)));
  endproperty
  a_dbl_exponent: assert property (p_dbl_exponent) else $error("double exponent not larger minus 48"); // [RL6]

  property p_ovf_exponent;
    (s_issue_legal and (!is_dbl && !res_neg && coef_ovf))
      |=> (result_data_o[SIGN_POS-1:EXP_LO] == $past(11'(exp_big + EXP_BIAS + 12'sh001)));
  endproperty
  a_ovf_exponent: assert property (p_ovf_exponent) else $error("overflow did not raise exponent"); // [RL7]

  property p_fill_sign;
    (j_big && (exp_gap > FILL_LIMIT)) |-> (al_k == (ext_k[EXT_W-1] ? {EXT_W{1'b1}} : {EXT_W{1'b0}}));
  endproperty
  a_fill_sign: assert property (p_fill_sign) else $error("far shifted operand not sign filled"); // [RL9]

  property p_inf_exit;
    (s_issue_legal and is_inf(word_j)) |=> exit_infinite_o;
  endproperty
  a_inf_exit: assert property (p_inf_exit) else $error("infinite operand raised no exit"); // [RL10]

  property p_ind_exit;
    (s_issue_legal and is_ind(word_k)) |=> exit_indefinite_o;
  endproperty
  a_ind_exit: assert property (p_ind_exit) else $error("indefinite operand raised no exit"); // [RL11]

  property p_round_tie;
    (is_rnd && (exp_j == exp_k)) |-> rnd_k;
  endproperty
  a_round_tie: assert property (p_round_tie) else $error("equal exponents did not round k"); // [RL12]

  property p_no_round_plain;
    !is_rnd |-> !rnd_j && !rnd_k && (ext_j[COEF_W-1:0] == '0);
  endproperty
  a_no_round_plain: assert property (p_no_round_plain) else $error("round bit on unrounded op"); // [RL13]

endmodule

`default_nettype wire

// >>> fasu_regfile_model.sv
/*
  operand register file model standing in for the issue side:
  eight 60-bit words, read selects answered in the same cycle.
  assumes the unit writes back through result_valid_o on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module fasu_regfile_model
  import fasu_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic [SEL_W-1:0]  first_sel_i,
  input  wire logic [SEL_W-1:0]  second_sel_i,
  output logic      [WORD_W-1:0] first_data_o,
  output logic      [WORD_W-1:0] second_data_o,
  input  wire logic              write_en_i,
  input  wire logic [SEL_W-1:0]  write_idx_i,
  input  wire logic [WORD_W-1:0] write_data_i
);
  // ******************************************************
  // storage and ports
  // ******************************************************
  logic [WORD_W-1:0] regs [8];

  initial
  begin
    for (int n = 0; n < 8; n++)
      regs[n] = '0;
  end

  assign first_data_o  = regs[first_sel_i];
  assign second_data_o = regs[second_sel_i];

  always @(posedge sys_clk_i)
  begin
    if (write_en_i)
      regs[write_idx_i] <= write_data_i;
  end

  task automatic load(input int idx, input logic [WORD_W-1:0] val);
    regs[idx] = val;
  endtask
endmodule

`default_nettype wire

// >>> fasu_float_add_sub_tb.sv
/*
  self-checking bench for the floating add and subtract unit.
  assumes fasu_pkg and fasu_regfile_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module fasu_float_add_sub_tb
  import fasu_pkg::*;
;
  localparam logic [10:0] EB = 11'h400;
  logic              sys_clk_i;
  logic              rstn_i;
  logic              issue_valid_i;
  logic [OPC_W-1:0]  opcode_i;
  logic [SEL_W-1:0]  dest_operand_reg_i;
  logic [SEL_W-1:0]  first_source_reg_i;
  logic [SEL_W-1:0]  second_source_reg_i;
  logic [SEL_W-1:0]  first_source_sel_o;
  logic [SEL_W-1:0]  second_source_sel_o;
  logic [SEL_W-1:0]  result_dest_o;
  logic [WORD_W-1:0] first_source_data_i;
  logic [WORD_W-1:0] second_source_data_i;
  logic [WORD_W-1:0] result_data_o;
  logic              result_valid_o;
  logic              exit_infinite_o;
  logic              exit_indefinite_o;
  int                err_total = 0;
  int                checked = 0;
  int                cyc = 0;

  fasu_float_add_sub dut (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .issue_valid_i(issue_valid_i), .opcode_i(opcode_i),
    .dest_operand_reg_i(dest_operand_reg_i), .first_source_reg_i(first_source_reg_i),
    .second_source_reg_i(second_source_reg_i), .first_source_sel_o(first_source_sel_o),
    .second_source_sel_o(second_source_sel_o), .first_source_data_i(first_source_data_i),
    .second_source_data_i(second_source_data_i), .result_valid_o(result_valid_o),
    .result_dest_o(result_dest_o), .result_data_o(result_data_o),
    .exit_infinite_o(exit_infinite_o), .exit_indefinite_o(exit_indefinite_o));

  fasu_regfile_model rf (
    .sys_clk_i(sys_clk_i), .first_sel_i(first_source_sel_o), .second_sel_i(second_source_sel_o),
    .first_data_o(first_source_data_i), .second_data_o(second_source_data_i),
    .write_en_i(result_valid_o), .write_idx_i(result_dest_o), .write_data_i(result_data_o));

  // ******************************************************
  // clock, timeout, helpers
  // ******************************************************
  initial
  begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      err_total++;
      results();
    end
  end

  function automatic logic [WORD_W-1:0] w(input logic [10:0] e, input logic [47:0] c);
    return {1'b0, e, c};
  endfunction

  task automatic tick;
    @(posedge sys_clk_i);
    #1;
  endtask

  task automatic chk(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp, input string m);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // issue stays high between calls so back-to-back ops never re-raise it in one time step
  task automatic op(input logic [OPC_W-1:0] opc, input logic [SEL_W-1:0] i, j, k,
                    input logic [WORD_W-1:0] exp, input string m, input bit cd = 1'b1);
    if (issue_valid_i !== 1'b1)
      issue_valid_i = 1'b1;
    opcode_i = opc;
    dest_operand_reg_i = i;
    first_source_reg_i = j;
    second_source_reg_i = k;
    #2;
    chk(first_source_sel_o, j, "j select");
    chk(second_source_sel_o, k, "k select");
    tick();
    chk(result_valid_o, 1'b1, "result valid");
    chk(result_dest_o, i, "result dest");
    if (cd)
      chk(result_data_o, exp, m);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ******************************************************
  // scenarios
  // ******************************************************
  task automatic t_plain;
    rf.load(0, w(EB, 48'h8000_0000_0003));
    rf.load(1, w(EB, 48'h8000_0000_0001));
    rf.load(2, w(EB, 48'h0000_0000_0003));
    op(OPC_SUM, 3'h3, 3'h0, 3'h2, w(EB, 48'h8000_0000_0006), "sum");
    op(OPC_DIFF, 3'h4, 3'h0, 3'h1, w(EB, 48'h0000_0000_0002), "like diff");
    op(OPC_DIFF, 3'h5, 3'h1, 3'h0, ~w(EB, 48'h0000_0000_0002), "neg diff");
    chk(exit_infinite_o | exit_indefinite_o, 1'b0, "no exit");
    issue_valid_i = 1'b0;
    tick();
    chk(rf.regs[4], w(EB, 48'h0000_0000_0002), "write back");
    op(OPC_SUM, 3'h6, 3'h2, 3'h5, w(EB, 48'h0000_0000_0001), "unlike sum");
    $display("test plain done");
  endtask

  task automatic t_align;
    rf.load(0, w(11'h404, 48'h0000_0000_1000));
    rf.load(1, w(EB, 48'h0000_0000_000f));
    op(OPC_SUM, 3'h2, 3'h0, 3'h1, w(11'h404, 48'h0000_0000_1000), "align sum");
    op(OPC_DSUM, 3'h2, 3'h0, 3'h1, w(11'h3d4, 48'hf000_0000_0000), "dsum");
    op(OPC_DIFF, 3'h2, 3'h0, 3'h1, w(11'h404, 48'h0000_0000_0fff), "align diff");
    op(OPC_DDIFF, 3'h2, 3'h0, 3'h1, w(11'h3d4, 48'h1000_0000_0000), "ddiff");
    rf.load(0, w(11'h4c8, 48'h0000_0000_0005));
    rf.load(1, w(EB, 48'hffff_ffff_ffff));
    op(OPC_SUM, 3'h2, 3'h0, 3'h1, w(11'h4c8, 48'h0000_0000_0005), "far sum");
    $display("test align done");
  endtask

  task automatic t_ovf;
    rf.load(0, w(EB, 48'h8000_0000_0000));
    rf.load(1, w(EB, 48'h8000_0000_0001));
    rf.load(4, ~w(EB, 48'h8000_0000_0001));
    op(OPC_SUM, 3'h3, 3'h0, 3'h1, w(11'h401, 48'h8000_0000_0000), "ovf sum");
    op(OPC_DIFF, 3'h3, 3'h0, 3'h4, w(11'h401, 48'h8000_0000_0000), "ovf diff");
    op(OPC_RSUM, 3'h3, 3'h0, 3'h1, w(11'h401, 48'h8000_0000_0001), "two rounds");
    $display("test overflow done");
  endtask

  task automatic t_round;
    rf.load(0, w(EB, 48'h0000_0000_0001));
    rf.load(1, w(EB, 48'h0000_0000_0002));
    op(OPC_RSUM, 3'h2, 3'h0, 3'h1, w(EB, 48'h0000_0000_0003), "one round");
    rf.load(0, w(11'h401, 48'h0000_0000_0004));
    rf.load(1, w(EB, 48'h0000_0000_0003));
    op(OPC_RSUM, 3'h2, 3'h0, 3'h1, w(11'h401, 48'h0000_0000_0006), "larger exp");
    rf.load(0, w(11'h401, 48'h8000_0000_0000));
    rf.load(1, w(EB, 48'h8000_0000_0002));
    op(OPC_RSUM, 3'h2, 3'h0, 3'h1, w(11'h401, 48'hc000_0000_0001), "pre shift");
    rf.load(0, w(EB, 48'h0000_0000_0005));
    rf.load(1, w(EB, 48'h0000_0000_0002));
    op(OPC_RDIFF, 3'h2, 3'h0, 3'h1, w(EB, 48'h0000_0000_0003), "rdiff like");
    rf.load(1, ~w(EB, 48'h0000_0000_0002));
    op(OPC_RDIFF, 3'h2, 3'h0, 3'h1, w(EB, 48'h0000_0000_0007), "rdiff unlike");
    op(OPC_RSUM, 3'h2, 3'h0, 3'h1, w(EB, 48'h0000_0000_0003), "rsum unlike");
    $display("test round done");
  endtask

  task automatic t_exits;
    logic [11:0] tops [4];
    tops = '{12'h7ff, 12'h800, 12'h3ff, 12'hc00};
    for (int n = 0; n < 4; n++)
    begin
      rf.load(n % 2, {tops[n], 48'h0000_0000_0001});
      rf.load(1 - n % 2, w(EB, 48'h0000_0000_0001));
      op(OPC_SUM, 3'h2, 3'h0, 3'h1, '0, "exit", 1'b0);
      chk(exit_infinite_o, n < 2, "infinite flag");
      chk(exit_indefinite_o, n >= 2, "indefinite flag");
    end
    $display("test exits done");
  endtask

  task automatic t_misc;
    rf.load(0, w(EB, 48'h0000_0000_0001));
    rf.load(1, w(EB, 48'h0000_0000_0002));
    op(OPC_DIFF, 3'h5, 3'h0, 3'h0, w(EB, 48'h0000_0000_0000), "self diff");
    op(OPC_SUM, 3'h3, 3'h0, 3'h1, w(EB, 48'h0000_0000_0003), "b2b a");
    op(OPC_DIFF, 3'h4, 3'h1, 3'h0, w(EB, 48'h0000_0000_0001), "b2b b");
    issue_valid_i = 1'b1;
    opcode_i = 6'h1e;
    dest_operand_reg_i = 3'h7;
    tick();
    issue_valid_i = 1'b0;
    chk(result_valid_o, 1'b0, "illegal valid");
    chk(result_data_o, w(EB, 48'h0000_0000_0001), "data holds");
    chk(result_dest_o, 3'h4, "dest holds");
    chk(exit_infinite_o | exit_indefinite_o, 1'b0, "illegal exit");
    $display("test misc done");
  endtask

  task automatic t_reset;
    rstn_i = 1'b0;
    #1;
    chk(result_data_o, '0, "mid reset data");
    chk(result_dest_o, '0, "mid reset dest");
    chk(result_valid_o, 1'b0, "mid reset valid");
    tick();
    rstn_i = 1'b1;
    tick();
    chk(result_valid_o, 1'b0, "after reset valid");
    chk(exit_infinite_o | exit_indefinite_o, 1'b0, "after reset exit");
    $display("test reset done");
  endtask

  // ******************************************************
  // main sequence
  // ******************************************************
  initial
  begin
    rstn_i = 1'b0;
    issue_valid_i = 1'b0;
    opcode_i = '0;
    dest_operand_reg_i = '0;
    first_source_reg_i = '0;
    second_source_reg_i = '0;
    repeat (12) @(posedge sys_clk_i);
    #1;
    rstn_i = 1'b1;
    chk(result_valid_o, 1'b0, "reset valid");
    chk(result_data_o, '0, "reset data");
    chk(result_dest_o, '0, "reset dest");
    t_plain();
    t_align();
    t_ovf();
    t_round();
    t_exits();
    t_misc();
    t_reset();
    results();
  end
endmodule

`default_nettype wire
